//--- design/fpx_flash_mode.v
// fpx_flash_mode.v: flash access mode decoder, tester port and external rom port
// assumes: one 250 MHz clock; controller fetch handshake on the same clock;
// embedded flash port on the same clock; scan pins split into in/out/enable
`timescale 1ns/10ps
`include "fpx_defs.vh"

// Summary of operation
// R01: tester-only pin connects flash to tester port
// R02: tester mode muxes scan pins to tester
// R03: program-mode pin holds controller reset low
// R04: tester mode lifts all write protection
// R05: leaving tester mode restores normal operation
// R06: tester port pin set: addr, mux, strobes
// R07: tester pulses latch, then write strobe
// R08: write data captured at write strobe rise
// R09: latch waits until strobes return high
// R10: read data driven while read strobe low
// R11: tester waits after program before reading
// R12: external rom routes controller fetches outward
// R13: external rom mode muxes scan pins
// R14: embedded flash held reset in external mode
// R15: external port issues only read cycles
// R16: external port scan pin map fixed
// R17: drive address, latch, float, sample byte
// R18: latch and read widths from clock counts
// R19: write-select bit steers data-move write strobe
// R20: both pins asserted selects monitor mode
// R21: tester data bus driven only while reading
// R22: mode pins synchronised before use
module fpx_flash_mode #(
  parameter ALE_CYC = `FPX_ALE_CYC,
  parameter RD_CYC = `FPX_RD_CYC,
  parameter ALE2RD_CYC = `FPX_ALE2RD_CYC,
  parameter FLOAT_CYC = `FPX_FLOAT_CYC
) (
  input wire clk,
  input wire rst,
  input wire programModePin,
  input wire externalRomSelect_n,
  input wire [11:0] scanOutputPinIn,
  output reg [11:0] scanOutputPinOut,
  output reg [11:0] scanOutputPinOe,
  input wire [6:0] scanInputPinIn,
  output reg [6:0] scanInputPinOut,
  output reg [6:0] scanInputPinOe,
  input wire cpuFetchReq,
  input wire [15:0] cpuFetchAddr,
  output reg cpuFetchDone,
  output reg [7:0] cpuFetchData,
  output reg cpuRst_n,
  input wire [7:0] specialFunctionControlReg,
  input wire cpuDataWrite,
  output reg cpuDataRamWr_n,
  output reg cpuCodeWr_n,
  output reg flashToTester,
  output reg flashToCpu,
  output reg flashReset,
  output reg flashReadArray,
  output reg writeProtectOff,
  output reg [15:0] flashAddr,
  output reg [7:0] flashWrData,
  output reg flashWr,
  output reg flashRd,
  input wire [7:0] flashRdData,
  output reg monitorMode
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // synchronised mode pins (bit1 program mode, bit0 ext rom asserted)
  wire [1:0] modeSync;
  // synchronised tester inputs: addr high, mux byte, strobes
  wire [7:0] tAddrHighSync;
  wire [7:0] tMuxSync;
  wire tLatchSync;
  wire tRdSync_n;
  wire tWrSync_n;

  fpx_sync2 #(.WIDTH(2)) uModeSync (
    .clk(clk),
    .rst(rst),
    .asyncIn({programModePin, ~externalRomSelect_n}),
    .syncOut(modeSync)
  ); // R22

  // tester signals share the scan pins; see pin map
  fpx_sync2 #(.WIDTH(19)) uPinSync (
    .clk(clk),
    .rst(rst),
    .asyncIn({scanOutputPinIn[7:0], scanOutputPinIn[11:8], scanInputPinIn[3:0],
              scanInputPinIn[4], scanInputPinIn[5], scanInputPinIn[6]}),
    .syncOut({tAddrHighSync, tMuxSync, tLatchSync, tRdSync_n, tWrSync_n})
  ); // R06

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // decoder on synchronised pins
  function [1:0] fpxDecode;
    input [1:0] pins;
    begin
      case (pins)
        2'b10: fpxDecode = `FPX_MODE_TESTER; // R01
        2'b01: fpxDecode = `FPX_MODE_EXTROM; // R12
        2'b11: fpxDecode = `FPX_MODE_MONITOR; // R20
        default: fpxDecode = `FPX_MODE_NORMAL;
      endcase
    end
  endfunction

  // current mode
  wire [1:0] modeNow = fpxDecode(modeSync);
  wire testerMode = (modeNow == `FPX_MODE_TESTER);
  wire extMode = (modeNow == `FPX_MODE_EXTROM);
  // previous mode, for the exit pulse
  reg [1:0] mode_reg;

  // ****************************************************************
  // tester port: latch, write capture, read drive
  // ****************************************************************
  // latched low address
  reg [7:0] tLowAddr_reg;
  // previous strobe levels for edge detection
  reg tLatchPrev_reg;
  reg tWrPrev_reg;
  // read in flight
  reg tRdActive_reg;

  // external port state machine, one-hot
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ALE = 5'h02;
  localparam [4:0] ST_SETUP = 5'h04;
  localparam [4:0] ST_READ = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  // cycle counter for strobe widths
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  // captured fetch address
  reg [15:0] eAddr_reg;

  // next state of the external read sequence
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg + 8'h01;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 8'h00;
        if (extMode && cpuFetchReq) begin
          state_next = ST_ALE;
        end
      end
      ST_ALE: begin
        if (cnt_reg == ALE_CYC[7:0] - 8'h01) begin
          state_next = ST_SETUP; // R18
          cnt_next = 8'h00;
        end
      end
      ST_SETUP: begin
        if (cnt_reg == ALE2RD_CYC[7:0] - 8'h01) begin
          state_next = ST_READ;
          cnt_next = 8'h00;
        end
      end
      ST_READ: begin
        if (cnt_reg == RD_CYC[7:0] - 8'h01) begin
          state_next = ST_DONE; // R18
          cnt_next = 8'h00;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!extMode) begin
      state_next = ST_IDLE;
    end
  end

  // main sequential process
  always @(posedge clk) begin
    if (rst) begin
      mode_reg <= `FPX_MODE_NORMAL;
      tLowAddr_reg <= 8'h00;
      tLatchPrev_reg <= 1'b0;
      tWrPrev_reg <= 1'b1;
      tRdActive_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      eAddr_reg <= 16'h0000;
      scanOutputPinOut <= 12'h000;
      scanOutputPinOe <= 12'h000;
      scanInputPinOut <= 7'h00;
      scanInputPinOe <= 7'h00;
      cpuFetchDone <= 1'b0;
      cpuFetchData <= 8'h00;
      cpuRst_n <= 1'b0;
      cpuDataRamWr_n <= 1'b1;
      cpuCodeWr_n <= 1'b1;
      flashToTester <= 1'b0;
      flashToCpu <= 1'b1;
      flashReset <= 1'b0;
      flashReadArray <= 1'b0;
      writeProtectOff <= 1'b0;
      flashAddr <= 16'h0000;
      flashWrData <= 8'h00;
      flashWr <= 1'b0;
      flashRd <= 1'b0;
      monitorMode <= 1'b0;
    end else begin
      mode_reg <= modeNow;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      tLatchPrev_reg <= tLatchSync;
      tWrPrev_reg <= tWrSync_n;
      // connections and reset follow the decoded mode
      flashToTester <= testerMode; // R01
      flashToCpu <= ~testerMode & ~extMode; // R05 R12
      writeProtectOff <= testerMode; // R04
      flashReset <= extMode; // R14
      cpuRst_n <= ~modeSync[1]; // R03
      monitorMode <= (modeNow == `FPX_MODE_MONITOR); // R20
      // one-cycle pulse back to read-array on tester exit
      flashReadArray <= (mode_reg == `FPX_MODE_TESTER) & ~testerMode; // R05
      // data-move write strobe steering
      cpuCodeWr_n <= ~(cpuDataWrite & specialFunctionControlReg[`FPX_WRSEL_BIT]); // R19
      cpuDataRamWr_n <= ~(cpuDataWrite & ~specialFunctionControlReg[`FPX_WRSEL_BIT]); // R19
      flashWr <= 1'b0;
      flashRd <= 1'b0;
      cpuFetchDone <= 1'b0;
      if (testerMode) begin
        // latch low address on the falling edge of the latch strobe
        if (tLatchPrev_reg && !tLatchSync) begin
          tLowAddr_reg <= tMuxSync; // R07
        end
        flashAddr <= {tAddrHighSync, tLowAddr_reg};
        // capture write data at the write strobe rise; the previous cycle must
        // also be tester mode, so the synchroniser filling after reset is no edge
        if (!tWrPrev_reg && tWrSync_n && (mode_reg == `FPX_MODE_TESTER)) begin
          flashWrData <= tMuxSync; // R08
          flashWr <= 1'b1; // R08
        end
        // read strobe low: fetch and drive the mux bus
        tRdActive_reg <= ~tRdSync_n;
        flashRd <= ~tRdSync_n; // R10
        scanOutputPinOe <= {{4{~tRdSync_n}}, 8'h00}; // R21 R02
        scanInputPinOe <= {3'b000, {4{~tRdSync_n}}}; // R21
        scanOutputPinOut <= {flashRdData[7:4], 8'h00}; // R10
        scanInputPinOut <= {3'b000, flashRdData[3:0]}; // R10
      end else if (extMode) begin
        tRdActive_reg <= 1'b0;
        // fetch sequence drives the scan pins
        case (state_reg)
          ST_IDLE: begin
            eAddr_reg <= cpuFetchAddr;
            scanOutputPinOe <= 12'hFFF; // R13
            scanInputPinOe <= 7'h7F; // R16
            scanOutputPinOut <= {cpuFetchAddr[7:4], cpuFetchAddr[15:8]}; // R16
            scanInputPinOut <= {3'b110, cpuFetchAddr[3:0]}; // R15
          end
          ST_ALE: begin
            scanInputPinOut <= {3'b111, eAddr_reg[3:0]}; // R17
          end
          ST_SETUP: begin
            scanInputPinOut <= {3'b110, eAddr_reg[3:0]};
          end
          ST_READ: begin
            // read strobe low, write strobe held high
            scanInputPinOut <= {3'b100, eAddr_reg[3:0]}; // R15
            if (cnt_reg == FLOAT_CYC[7:0] - 8'h01) begin
              scanOutputPinOe <= 12'h0FF; // R17
              scanInputPinOe <= 7'h70; // R17
            end
          end
          ST_DONE: begin
            cpuFetchData <= {tMuxSync[7:4], tMuxSync[3:0]}; // R17
            cpuFetchDone <= 1'b1;
            scanInputPinOut <= {3'b110, eAddr_reg[3:0]};
          end
          default: begin
            scanInputPinOut <= 7'h60;
          end
        endcase
      end else begin
        tRdActive_reg <= 1'b0;
        // normal or monitor: pins released to their other users
        scanOutputPinOe <= 12'h000;
        scanInputPinOe <= 7'h00;
        scanOutputPinOut <= 12'h000;
        scanInputPinOut <= 7'h00;
        flashAddr <= cpuFetchAddr;
        flashRd <= cpuFetchReq;
        if (modeNow == `FPX_MODE_NORMAL) begin
          cpuFetchData <= flashRdData;
          cpuFetchDone <= cpuFetchReq;
        end
      end
    end
  end
endmodule // fpx_flash_mode

//--- shared/fpx_defs.vh
// fpx_defs.vh: constants for the flash access mode block
// assumes: included by the mode decoder design file of the flash access mode block; the synchroniser does not include it
`ifndef FPX_DEFS_VH
`define FPX_DEFS_VH
// clock period in picoseconds (250 MHz)
`define FPX_CLK_PS 4000
// external latch strobe width, ns
`define FPX_ALE_NS 125
// external read strobe width, ns
`define FPX_RD_NS 160
// latch low to read strobe low, ns (address setup after latch)
`define FPX_ALE2RD_NS 5
// bus float delay after read strobe falls, ns
`define FPX_FLOAT_NS 5
// derived cycle counts; widths round down, setups round up, no floor at one
`define FPX_ALE_CYC ((`FPX_ALE_NS * 1000) / `FPX_CLK_PS)
`define FPX_RD_CYC ((`FPX_RD_NS * 1000) / `FPX_CLK_PS)
`define FPX_ALE2RD_CYC (((`FPX_ALE2RD_NS * 1000) + `FPX_CLK_PS - 1) / `FPX_CLK_PS)
`define FPX_FLOAT_CYC (((`FPX_FLOAT_NS * 1000) + `FPX_CLK_PS - 1) / `FPX_CLK_PS)
// mode decoder codes
`define FPX_MODE_NORMAL 2'h0
`define FPX_MODE_TESTER 2'h1
`define FPX_MODE_EXTROM 2'h2
`define FPX_MODE_MONITOR 2'h3
// write-select bit position in the special function control register
`define FPX_WRSEL_BIT 0
`endif

//--- design/fpx_sync2.v
// fpx_sync2.v: two-flop level synchroniser, parameterised width
// assumes: inputs come from pins outside the clock domain
`timescale 1ns/10ps
module fpx_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  // first stage, read only by the second
  reg [WIDTH-1:0] meta_reg;
  // second stage, safe to use
  reg [WIDTH-1:0] sync_reg;

  // two flops in series
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule // fpx_sync2

//--- tb/fpx_flash_mode_asserts.sv
// fpx_flash_mode_asserts.sv: port checker for the flash mode block
// assumes: bound into fpx_flash_mode; one clock, sync reset
`timescale 1ns/10ps
module fpx_flash_mode_asserts #(
  parameter ALE_CYC = 31,
  parameter RD_CYC = 40
) (
  input wire clk,
  input wire rst,
  input wire programModePin,
  input wire externalRomSelect_n,
  input wire [6:0] scanInputPinOut,
  input wire [6:0] scanInputPinOe,
  input wire cpuRst_n,
  input wire [7:0] specialFunctionControlReg,
  input wire cpuDataWrite,
  input wire cpuDataRamWr_n,
  input wire cpuCodeWr_n,
  input wire flashToTester,
  input wire flashToCpu,
  input wire flashReset,
  input wire flashReadArray,
  input wire writeProtectOff,
  input wire monitorMode
);
  // ****
  // strobe width counters
  // ****
  wire latchOn = scanInputPinOe[4] & scanInputPinOut[4] & flashReset;
  wire readOn = scanInputPinOe[5] & ~scanInputPinOut[5] & flashReset;
  integer latchCnt_reg; // cycles the latch strobe stood high
  integer readCnt_reg; // cycles the read strobe stood low
  // count while each strobe is active, clear otherwise
  always @(posedge clk) begin
    latchCnt_reg <= (rst | ~latchOn) ? 0 : latchCnt_reg + 1;
    readCnt_reg <= (rst | ~readOn) ? 0 : readCnt_reg + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_CPU_HELD: assert property (programModePin [*5] |-> !cpuRst_n)
    else $error("controller not held in reset");
  AST_TESTER_MODE: assert property ((programModePin && externalRomSelect_n) [*5]
    |-> flashToTester && writeProtectOff && !flashToCpu)
    else $error("tester mode outputs wrong");
  AST_EXT_MODE: assert property ((!programModePin && !externalRomSelect_n) [*5]
    |-> flashReset && !flashToCpu && !flashToTester)
    else $error("external rom mode outputs wrong");
  AST_MONITOR: assert property ((programModePin && !externalRomSelect_n) [*5]
    |-> monitorMode && !flashToTester)
    else $error("both pins did not give monitor mode");
  AST_READ_ARRAY: assert property ($fell(flashToTester) |-> ##[0:2] flashReadArray)
    else $error("no read array on tester exit");
  AST_NO_EXT_WRITE: assert property (flashReset && scanInputPinOe[6] |-> scanInputPinOut[6])
    else $error("external write strobe asserted");
  AST_LATCH_WIDTH: assert property ($fell(latchOn) |-> latchCnt_reg == ALE_CYC)
    else $error("external latch width wrong");
  AST_READ_WIDTH: assert property ($fell(readOn) |-> readCnt_reg == RD_CYC)
    else $error("external read width wrong");
  AST_CODE_WR: assert property (cpuDataWrite |=>
    cpuCodeWr_n == !$past(specialFunctionControlReg[0])
    && cpuDataRamWr_n == $past(specialFunctionControlReg[0]))
    else $error("write strobe select wrong");
endmodule // fpx_flash_mode_asserts

bind fpx_flash_mode fpx_flash_mode_asserts #(.ALE_CYC(ALE_CYC), .RD_CYC(RD_CYC))
  fpx_flash_mode_asserts_i (.clk(clk), .rst(rst), .programModePin(programModePin),
  .externalRomSelect_n(externalRomSelect_n), .scanInputPinOut(scanInputPinOut),
  .scanInputPinOe(scanInputPinOe), .cpuRst_n(cpuRst_n),
  .specialFunctionControlReg(specialFunctionControlReg), .cpuDataWrite(cpuDataWrite),
  .cpuDataRamWr_n(cpuDataRamWr_n), .cpuCodeWr_n(cpuCodeWr_n),
  .flashToTester(flashToTester), .flashToCpu(flashToCpu), .flashReset(flashReset),
  .flashReadArray(flashReadArray), .writeProtectOff(writeProtectOff),
  .monitorMode(monitorMode));

//--- tb/fpx_ext_rom_model.sv
// fpx_ext_rom_model.sv: behavioural external code rom on the scan pins
// assumes: strobes come from the block; chipEnable high while selected
`timescale 1ns/10ps
module fpx_ext_rom_model (
  input wire chipEnable,
  input wire [7:0] addrHigh,
  input wire [7:0] addrDataMux,
  input wire addrLatch,
  input wire readStrobe_n,
  output wire [7:0] romData,
  output wire romDrive
);
  reg [7:0] lowAddr_reg = 8'h00; // low address held by the latch
  reg [7:0] lastData_reg = 8'h00; // last byte, inverted on release
  wire [7:0] romByte = addrHigh ^ lowAddr_reg ^ 8'hA5;
  // capture low address as the latch strobe falls
  always @(negedge addrLatch) lowAddr_reg <= addrDataMux;
  // remember the byte handed out
  always @(posedge readStrobe_n) lastData_reg <= romByte;
  // drive only while selected and read strobe low
  assign romDrive = chipEnable & ~readStrobe_n;
  assign romData = romDrive ? romByte : ~lastData_reg;
endmodule // fpx_ext_rom_model

//--- tb/fpx_flash_mode_bench.sv
// fpx_flash_mode_bench.sv: self-checking bench for the flash mode block
// assumes: design, checker and rom model compiled first; 250 MHz clock
`timescale 1ns/10ps
module fpx_flash_mode_bench;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg program_mode_pin = 1'h0; // program mode pin
  reg eaN = 1'h1; // external rom select, low active
  reg [11:0] tbKo = 12'h000; // bench drive on scan outputs
  reg [6:0] tbKi = 7'h60; // bench drive on scan inputs, strobes idle
  reg req = 1'h0;
  reg [15:0] fAddr = 16'h0000;
  reg [7:0] sfr = 8'h00;
  reg dw = 1'h0;
  reg [7:0] fRd = 8'h3C; // embedded flash read byte
  integer error_cnt = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  integer k;
  wire [11:0] koOut, koOe, koPin;
  wire [6:0] kiOut, kiOe, kiPin;
  wire [7:0] mData, fData, wrData;
  wire [15:0] fAdr;
  wire mOe, done, cpuRst_n, ramWr_n, codeWr_n, toTester, toCpu, fReset;
  wire readArr, wpOff, fWr, fRdEn, monMode;
  // resolve pin levels: block first, then rom model, then bench
  wire [11:0] koDrv = mOe ? {mData[7:4], tbKo[7:0]} : tbKo;
  wire [6:0] kiDrv = mOe ? {tbKi[6:4], mData[3:0]} : tbKi;
  assign koPin = (koOe & koOut) | (~koOe & koDrv);
  assign kiPin = (kiOe & kiOut) | (~kiOe & kiDrv);
  wire [7:0] muxOut = {koOut[11:8], kiOut[3:0]};
  initial forever #2 clk = ~clk;
  fpx_flash_mode fpx_flash_mode_i (.clk(clk), .rst(rst), .programModePin(program_mode_pin),
    .externalRomSelect_n(eaN), .scanOutputPinIn(koPin), .scanOutputPinOut(koOut),
    .scanOutputPinOe(koOe), .scanInputPinIn(kiPin), .scanInputPinOut(kiOut),
    .scanInputPinOe(kiOe), .cpuFetchReq(req), .cpuFetchAddr(fAddr), .cpuFetchDone(done),
    .cpuFetchData(fData), .cpuRst_n(cpuRst_n), .specialFunctionControlReg(sfr),
    .cpuDataWrite(dw), .cpuDataRamWr_n(ramWr_n), .cpuCodeWr_n(codeWr_n),
    .flashToTester(toTester), .flashToCpu(toCpu), .flashReset(fReset),
    .flashReadArray(readArr), .writeProtectOff(wpOff), .flashAddr(fAdr),
    .flashWrData(wrData), .flashWr(fWr), .flashRd(fRdEn), .flashRdData(fRd),
    .monitorMode(monMode));
  fpx_ext_rom_model fpx_ext_rom_model_i (.chipEnable(~eaN), .addrHigh(koPin[7:0]),
    .addrDataMux({koPin[11:8], kiPin[3:0]}), .addrLatch(kiPin[4]),
    .readStrobe_n(kiPin[5]), .romData(mData), .romDrive(mOe));
  // ****
  // helpers
  // ****
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // tester address phase: high byte, low byte, latch pulse
  task latchAddr(input [15:0] a);
    tbKo = {a[7:4], a[15:8]};
    tbKi[3:0] = a[3:0];
    tbKi[4] = 1'h1;
    step(13);
    tbKi[4] = 1'h0;
    step(2);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task t_tester;
    program_mode_pin = 1'h1;
    step(5);
    chkb("cpuRst_n", 1'h0, cpuRst_n);
    chkb("toTester", 1'h1, toTester);
    chkb("wpOff", 1'h1, wpOff);
    latchAddr(16'h1234);
    {tbKo[11:8], tbKi[3:0]} = 8'hC7;
    tbKi[6] = 1'h0;
    step(13);
    tbKi[6] = 1'h1;
    for (i = 0; i < 8 && fWr !== 1'h1; i = i + 1) step(1);
    chkb("flashWr", 1'h1, fWr);
    chk("flashAddr", 16'h1234, fAdr);
    chk("wrData", 16'h00C7, {8'h00, wrData});
    step(12000);
    latchAddr(16'h56FF);
    chkb("muxOeIdle", 1'h0, koOe[8]);
    tbKi[5] = 1'h0;
    step(5);
    chkb("muxOeRead", 1'h1, koOe[8]);
    chk("rdData", {8'h00, fRd}, {8'h00, muxOut});
    chk("rdAddr", 16'h56FF, fAdr);
    chkb("flashRd", 1'h1, fRdEn);
    tbKi[5] = 1'h1;
    step(6);
    chkb("muxOeDone", 1'h0, koOe[8]);
    program_mode_pin = 1'h0;
    for (i = 0; i < 8 && readArr !== 1'h1; i = i + 1) step(1);
    chkb("readArr", 1'h1, readArr);
    step(2);
    chkb("cpuRun", 1'h1, cpuRst_n);
    chkb("wpOn", 1'h0, wpOff);
    chkb("toCpu", 1'h1, toCpu);
  endtask
  task t_ext;
    eaN = 1'h0;
    step(5);
    chkb("fReset", 1'h1, fReset);
    chkb("toCpuExt", 1'h0, toCpu);
    for (k = 0; k < 2; k = k + 1) begin
      fAddr = k ? 16'h00FF : 16'hBEEF;
      req = 1'h1;
      for (i = 0; i < 200 && done !== 1'h1; i = i + 1) step(1);
      req = 1'h0;
      chk("fetch", {8'h00, fAddr[15:8] ^ fAddr[7:0] ^ 8'hA5}, {8'h00, fData});
      chkb("extWr", 1'h1, kiPin[6]);
      step(1);
    end
    eaN = 1'h1;
    step(5);
  endtask
  task t_wrsel;
    for (k = 0; k < 2; k = k + 1) begin
      sfr = {7'h00, k[0]};
      dw = 1'h1;
      step(1);
      dw = 1'h0;
      chkb("codeWr_n", ~k[0], codeWr_n);
      chkb("ramWr_n", k[0], ramWr_n);
      step(1);
    end
    // normal mode: fetch answered by the embedded flash on the next edge
    fAddr = 16'h0123;
    req = 1'h1;
    step(1);
    req = 1'h0;
    chkb("normDone", 1'h1, done);
    chk("normData", {8'h00, fRd}, {8'h00, fData});
    step(1);
  endtask
  task t_monitor;
    program_mode_pin = 1'h1;
    eaN = 1'h0;
    step(5);
    chkb("monMode", 1'h1, monMode);
    chkb("noTester", 1'h0, toTester);
    program_mode_pin = 1'h0;
    eaN = 1'h1;
    step(5);
  endtask
  // main sequence
  initial begin
    step(12);
    chkb("rstCpu", 1'h0, cpuRst_n);
    rst = 1'h0;
    step(4);
    chkb("cpuUp", 1'h1, cpuRst_n);
    t_tester;
    t_ext;
    t_wrsel;
    t_monitor;
    report_and_stop;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
endmodule // fpx_flash_mode_bench
